// ### hdl/hpcb_pkg.sv
// Package of offsets, field positions, reset values and types for the hub port config bytes.
package hpcb_pkg;

    // ****************************************
    // Register map and reset values
    // ****************************************
    localparam logic [7:0] OFS_OWNER_CFG   = 8'h08;
    localparam logic [7:0] OFS_FIXED_MASK  = 8'h09;
    localparam logic [7:0] OFS_SP_DIS_MASK = 8'h0a;
    localparam logic [7:0] OFS_BP_DIS_MASK = 8'h0b;
    localparam logic [7:0] CFG_RESET       = 8'h00;

    // ****************************************
    // Field positions and masks
    // ****************************************
    localparam int STYLE_HI  = 7;
    localparam int STYLE_LO  = 6;
    localparam int SRC_BIT   = 5;
    localparam int IND_HI    = 2;
    localparam int IND_LO    = 1;
    localparam int STR_BIT   = 0;
    localparam logic [7:0] OWNER_WMASK = 8'he7;
    localparam logic [7:0] PORT_WMASK  = 8'h1e;
    localparam int PORT_LO   = 1;
    localparam int PORT_HI   = 4;

    // ****************************************
    // Modes
    // ****************************************
    typedef enum logic [1:0] {
        HPCB_OWN_PROG3  = 2'h0,
        HPCB_OWN_LEVEL4 = 2'h1,
        HPCB_OWN_EDGE4  = 2'h2,
        HPCB_OWN_EDGEU4 = 2'h3
    } hpcb_style_e;

    typedef enum logic [1:0] {
        HPCB_IND_ACT0  = 2'h0,
        HPCB_IND_SPEED = 2'h1,
        HPCB_IND_OWNER = 2'h2,
        HPCB_IND_ACT3  = 2'h3
    } hpcb_ind_e;

    typedef struct packed {
        logic       wrEn;
        logic       rdEn;
        logic [7:0] addr;
        logic [7:0] wdata;
    } hpcb_req_s;

    typedef struct packed {
        logic [1:0] fixedStraps;
        logic [1:0] disableStraps;
    } hpcb_strap_s;

endpackage

// ### hdl/hpcb_cfg_reg.sv
// One configuration byte with a write mask and a reset value.
`timescale 1ns/10ps
`default_nettype none
module hpcb_cfg_reg #(
    parameter logic [7:0] WMASK = 8'hff
) (
    input  wire logic       mclk,
    input  wire logic       sys_rst,
    input  wire logic       wrEn,
    input  wire logic [7:0] wdata,
    output var  logic [7:0] value
);
    logic [7:0] value_d;

    assign value_d = wrEn ? (wdata & WMASK) : value;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            value <= hpcb_pkg::CFG_RESET;
        end else begin
            value <= value_d;
        end
    end
endmodule
`default_nettype wire

// ### hdl/hpcb_port_owner.sv
// Per-port host ownership tracker for the four direct select inputs.
`timescale 1ns/10ps
`default_nettype none
module hpcb_port_owner (
    input  wire logic       mclk,
    input  wire logic       sys_rst,
    input  wire logic [1:0] style,
    input  wire logic       selIn,
    input  wire logic       unassignIn,
    output var  logic       owner_q,
    output var  logic       assigned_q
);
    logic selPrev_q;
    logic rise;
    logic unassignOk;

    assign rise       = selIn & ~selPrev_q;
    assign unassignOk = (style == hpcb_pkg::HPCB_OWN_EDGEU4);

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            selPrev_q  <= 1'b0;
            owner_q    <= 1'b0;
            assigned_q <= 1'b1;
        end else begin
            selPrev_q <= selIn;
            if (style == hpcb_pkg::HPCB_OWN_LEVEL4) begin
                owner_q    <= selIn;
                assigned_q <= 1'b1;
            end else if (unassignOk && unassignIn) begin
                assigned_q <= 1'b0;
            end else if (rise) begin
                owner_q    <= ~owner_q;
                assigned_q <= 1'b1;
            end else if (!unassignOk) begin
                assigned_q <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ### hdl/hpcb_top.sv
// Configuration byte bank for port ownership, indicators, fixed ports and port disables.
`timescale 1ns/10ps
`default_nettype none
// Contract
// - Mode 00: three-wire selector, eight configurations.
// - Mode 01: ownership follows select level.
// - Mode 10: edge control, never unassigned.
// - Mode 11: edge control with unassigned state.
// - Bit 5 picks pins or registers.
// - Indicator 00 or 11: bus activity.
// - 01 ownership plus speed; 10 ownership.
// - Bit 0 enables string descriptors.
// - Fixed mask bits 4:1 report fixed ports.
// - Reserved mask bits; bit 0 zero.
// - Default config uses fixed-port straps.
// - Self-powered mask disables marked ports.
// - Bus-powered mask applies when bus-powered.
// - Default config uses disable straps.
// - All four bytes reset to zero.
// - Power sense picks which mask applies.
// - Strapped fixed port reports compound device.
module hpcb_top #(
    parameter int NUM_CFG = 8
) (
    input  wire logic                mclk,
    input  wire logic                sys_rst,
    input  wire hpcb_pkg::hpcb_req_s req,
    input  wire logic                useDefaults,
    input  wire hpcb_pkg::hpcb_strap_s straps,
    input  wire logic                dynamicPowerEn,
    input  wire logic                local_power_sense,
    input  wire logic [2:0]          progSelect,
    input  wire logic [3:0]          portSelect,
    input  wire logic [3:0]          portUnassign,
    input  wire logic [3:0]          regOwner,
    input  wire logic [3:0]          portSpeedHigh,
    input  wire logic [3:0]          portActivity,
    output var  logic [7:0]          rdata_q,
    output var  logic                rvalid_q,
    output var  logic [3:0]          portOwner_q,
    output var  logic [3:0]          portAssigned_q,
    output var  logic [3:0]          portDisabled_q,
    output var  logic [3:0]          portFixed_q,
    output var  logic                compound_q,
    output var  logic                stringEn_q,
    output var  logic                selfPowered_q,
    output var  logic [3:0]          indicator_a_outputs_n_q,
    output var  logic [3:0]          indicator_b_outputs_n_q
);
    // ****************************************
    // Register bank
    // ****************************************
    logic [7:0] ownerCfg;
    logic [7:0] fixedMask;
    logic [7:0] spMask;
    logic [7:0] bpMask;
    logic       wrOwner;
    logic       wrFixed;
    logic       wrSp;
    logic       wrBp;

    assign wrOwner = req.wrEn && (req.addr == hpcb_pkg::OFS_OWNER_CFG);
    assign wrFixed = req.wrEn && (req.addr == hpcb_pkg::OFS_FIXED_MASK);
    assign wrSp    = req.wrEn && (req.addr == hpcb_pkg::OFS_SP_DIS_MASK);
    assign wrBp    = req.wrEn && (req.addr == hpcb_pkg::OFS_BP_DIS_MASK);

    hpcb_cfg_reg #(.WMASK(hpcb_pkg::OWNER_WMASK)) uOwner (
        .mclk(mclk), .sys_rst(sys_rst), .wrEn(wrOwner), .wdata(req.wdata), .value(ownerCfg)
    );
    hpcb_cfg_reg #(.WMASK(hpcb_pkg::PORT_WMASK)) uFixed (
        .mclk(mclk), .sys_rst(sys_rst), .wrEn(wrFixed), .wdata(req.wdata), .value(fixedMask)
    );
    hpcb_cfg_reg #(.WMASK(hpcb_pkg::PORT_WMASK)) uSp (
        .mclk(mclk), .sys_rst(sys_rst), .wrEn(wrSp), .wdata(req.wdata), .value(spMask)
    );
    hpcb_cfg_reg #(.WMASK(hpcb_pkg::PORT_WMASK)) uBp (
        .mclk(mclk), .sys_rst(sys_rst), .wrEn(wrBp), .wdata(req.wdata), .value(bpMask)
    );

    logic [7:0] rdMux;
    assign rdMux = (req.addr == hpcb_pkg::OFS_OWNER_CFG)   ? ownerCfg  :
                   (req.addr == hpcb_pkg::OFS_FIXED_MASK)  ? fixedMask :
                   (req.addr == hpcb_pkg::OFS_SP_DIS_MASK) ? spMask    :
                   (req.addr == hpcb_pkg::OFS_BP_DIS_MASK) ? bpMask    : 8'h00;

    // ****************************************
    // Decoded fields
    // ****************************************
    logic [1:0] ownership_interface_style;
    logic       ownership_source_select;
    logic [1:0] indicator_style_select;

    assign ownership_interface_style = ownerCfg[hpcb_pkg::STYLE_HI:hpcb_pkg::STYLE_LO];
    assign ownership_source_select   = ownerCfg[hpcb_pkg::SRC_BIT];
    assign indicator_style_select    = ownerCfg[hpcb_pkg::IND_HI:hpcb_pkg::IND_LO];

    // ****************************************
    // Strap defaults
    // ****************************************
    logic [3:0] fixedStrapMask;
    logic [3:0] disStrapMask;
    logic [3:0] fixedRegPorts;
    logic [3:0] fixedPorts;

    // Fixed straps name one port, or none when zero.
    assign fixedStrapMask = (straps.fixedStraps == 2'h0) ? 4'h0 :
                            (4'h1 << (straps.fixedStraps - 2'h1));
    // Disable straps count ports disabled downward from port four.
    assign disStrapMask = (straps.disableStraps == 2'h0) ? 4'h0 :
                          (straps.disableStraps == 2'h1) ? 4'h8 :
                          (straps.disableStraps == 2'h2) ? 4'hc : 4'he;
    assign fixedRegPorts = fixedMask[hpcb_pkg::PORT_HI:hpcb_pkg::PORT_LO];
    assign fixedPorts    = useDefaults ? fixedStrapMask : fixedRegPorts;

    // ****************************************
    // Power source and disables
    // ****************************************
    logic       selfPowered_d;
    logic [3:0] disPorts;

    assign selfPowered_d = dynamicPowerEn ? local_power_sense : selfPowered_q;
    assign disPorts = useDefaults ? disStrapMask :
                      selfPowered_q ? spMask[hpcb_pkg::PORT_HI:hpcb_pkg::PORT_LO]
                                    : bpMask[hpcb_pkg::PORT_HI:hpcb_pkg::PORT_LO];

    // ****************************************
    // Ownership
    // ****************************************
    logic [3:0] directOwner;
    logic [3:0] directAssigned;
    logic [3:0] progOwner;
    logic [3:0] pinOwner;
    logic [3:0] pinAssigned;
    logic [3:0] ownerSel;

    for (genvar p = 0; p < 4; p++) begin : gOwn
        hpcb_port_owner uPort (
            .mclk(mclk), .sys_rst(sys_rst), .style(ownership_interface_style),
            .selIn(portSelect[p]), .unassignIn(portUnassign[p]),
            .owner_q(directOwner[p]), .assigned_q(directAssigned[p])
        );
    end

    // Eight predefined configurations: selector bits 2:0 give owner bits 3:1, their parity gives owner bit 0.
    assign progOwner = {progSelect[2], progSelect[1], progSelect[0],
                        ^progSelect} & 4'hf;
    assign pinOwner = (ownership_interface_style == hpcb_pkg::HPCB_OWN_PROG3) ?
                      progOwner : directOwner;
    assign pinAssigned = (ownership_interface_style == hpcb_pkg::HPCB_OWN_PROG3) ?
                         4'hf : directAssigned;
    assign ownerSel = ownership_source_select ? regOwner : pinOwner;

    // ****************************************
    // Indicators
    // ****************************************
    logic [3:0] indA;
    logic [3:0] indB;

    always_comb begin
        indA = 4'h0;
        indB = 4'h0;
        case (indicator_style_select)
            hpcb_pkg::HPCB_IND_SPEED: begin
                indA = ~ownerSel & portSpeedHigh;
                indB = ownerSel & portSpeedHigh;
            end
            hpcb_pkg::HPCB_IND_OWNER: begin
                indA = ~ownerSel;
                indB = ownerSel;
            end
            default: begin
                indA = portActivity & ~ownerSel;
                indB = portActivity & ownerSel;
            end
        endcase
    end

    // ****************************************
    // Output registers
    // ****************************************
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rdata_q                 <= 8'h00;
            rvalid_q                <= 1'b0;
            portOwner_q             <= 4'h0;
            portAssigned_q          <= 4'h0;
            portDisabled_q          <= 4'h0;
            portFixed_q             <= 4'h0;
            compound_q              <= 1'b0;
            stringEn_q              <= 1'b0;
            selfPowered_q           <= 1'b1;
            indicator_a_outputs_n_q <= 4'hf;
            indicator_b_outputs_n_q <= 4'hf;
        end else begin
            rdata_q                 <= req.rdEn ? rdMux : 8'h00;
            rvalid_q                <= req.rdEn;
            portOwner_q             <= ownerSel;
            portAssigned_q          <= ownership_source_select ? 4'hf : pinAssigned;
            portDisabled_q          <= disPorts;
            portFixed_q             <= fixedPorts;
            compound_q              <= useDefaults && (fixedStrapMask != 4'h0);
            stringEn_q              <= ownerCfg[hpcb_pkg::STR_BIT];
            selfPowered_q           <= selfPowered_d;
            indicator_a_outputs_n_q <= ~(indA & ~disPorts);
            indicator_b_outputs_n_q <= ~(indB & ~disPorts);
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    rsv_owner_a: assert property (ownerCfg[4:3] == 2'h0)
        else $error("Reserved owner bits not zero.");
    rsv_port0_a: assert property (!fixedMask[0] && !spMask[0] && !bpMask[0])
        else $error("Port mask bit 0 not zero.");
    str_en_a: assert property (wrOwner ##1 1'b1 |=> stringEn_q == $past(req.wdata[0], 2))
        else $error("String enable does not follow write.");
    sp_dis_a: assert property (!useDefaults && selfPowered_q && !wrSp |=>
        portDisabled_q == $past(spMask[4:1]))
        else $error("Self-powered mask not applied.");
    bp_dis_a: assert property (!useDefaults && !selfPowered_q && !wrBp |=>
        portDisabled_q == $past(bpMask[4:1]))
        else $error("Bus-powered mask not applied.");
    pwr_sense_a: assert property (dynamicPowerEn |=> selfPowered_q == $past(local_power_sense))
        else $error("Power sense not followed.");
    compound_a: assert property (useDefaults && straps.fixedStraps != 2'h0 |=> compound_q)
        else $error("Compound not reported.");
    src_reg_a: assert property (ownership_source_select |=> portOwner_q == $past(regOwner))
        else $error("Register ownership not used.");
    level_a: assert property (!ownership_source_select &&
        ownership_interface_style == 2'h1 && $stable(ownerCfg) ##1 $stable(ownerCfg)
        |=> portOwner_q == $past(portSelect, 2))
        else $error("Level ownership not followed.");
    no_unas_a: assert property (ownership_interface_style == 2'h2 |=> directAssigned == 4'hf)
        else $error("Unassigned state in mode 10.");
    ind_own_a: assert property (indicator_style_select == 2'h2 && !useDefaults
        |=> indicator_a_outputs_n_q[0] == ($past(ownerSel[0]) | $past(disPorts[0])))
        else $error("Ownership indicator wrong.");
    ind_spd_a: assert property (indicator_style_select == 2'h1 && !portSpeedHigh[0]
        |=> indicator_a_outputs_n_q[0] && indicator_b_outputs_n_q[0])
        else $error("Speed indicator lit on a slow port.");
    ind_act_a: assert property ((indicator_style_select == 2'h0 ||
        indicator_style_select == 2'h3) && !portActivity[0]
        |=> indicator_a_outputs_n_q[0] && indicator_b_outputs_n_q[0])
        else $error("Activity indicator lit without activity.");
    prog_own_a: assert property (!ownership_source_select &&
        ownership_interface_style == 2'h0 |=> portOwner_q[3:1] == $past(progSelect))
        else $error("Selector ownership not followed.");
    unas_set_a: assert property (ownership_interface_style == 2'h3 && portUnassign[0]
        |=> !directAssigned[0])
        else $error("Unassigned state not entered.");
    edge_tog_a: assert property (ownership_interface_style == 2'h2 &&
        $rose(portSelect[0])
        |=> directOwner[0] != $past(directOwner[0]))
        else $error("Owner did not toggle on select edge.");

    // ****************************************
    // Bus, reset and strap checks
    // ****************************************
    rst_val_a: assert property ($fell(sys_rst) |->
        ownerCfg == hpcb_pkg::CFG_RESET && fixedMask == hpcb_pkg::CFG_RESET &&
        spMask == hpcb_pkg::CFG_RESET && bpMask == hpcb_pkg::CFG_RESET && selfPowered_q)
        else $error("Configuration bytes not reset.");
    rd_own_a: assert property (req.rdEn && req.addr == hpcb_pkg::OFS_OWNER_CFG
        |=> rvalid_q && rdata_q == $past(ownerCfg))
        else $error("Owner byte read wrong.");
    rd_fix_a: assert property (req.rdEn && req.addr == hpcb_pkg::OFS_FIXED_MASK
        |=> rvalid_q && rdata_q == $past(fixedMask))
        else $error("Fixed mask read wrong.");
    rd_sp_a: assert property (req.rdEn && req.addr == hpcb_pkg::OFS_SP_DIS_MASK
        |=> rvalid_q && rdata_q == $past(spMask))
        else $error("Self-powered mask read wrong.");
    rd_bp_a: assert property (req.rdEn && req.addr == hpcb_pkg::OFS_BP_DIS_MASK
        |=> rvalid_q && rdata_q == $past(bpMask))
        else $error("Bus-powered mask read wrong.");
    rd_idle_a: assert property (!req.rdEn |=> !rvalid_q && rdata_q == 8'h00)
        else $error("Read answer without a read.");
    fix_reg_a: assert property (!useDefaults |=>
        portFixed_q == $past(fixedMask[4:1]))
        else $error("Fixed mask not applied.");
    fix_strap_a: assert property (useDefaults && straps.fixedStraps == 2'h2
        |=> portFixed_q == 4'h2)
        else $error("Fixed-port straps not applied.");
    dis_strap_a: assert property (useDefaults && straps.disableStraps == 2'h3
        |=> portDisabled_q == 4'he)
        else $error("Disable straps not applied.");
    no_comp_a: assert property (!useDefaults |=> !compound_q)
        else $error("Compound reported without straps.");
    pwr_hold_a: assert property (!dynamicPowerEn |=>
        selfPowered_q == $past(selfPowered_q))
        else $error("Power state moved while tracking is off.");

    cv_edge_c: cover property (ownership_interface_style == 2'h3 && portUnassign[0]);
    cv_bus_c:  cover property (!selfPowered_q && bpMask != 8'h00);
    cv_prog_c: cover property (ownership_interface_style == 2'h0 && progSelect == 3'h7);
    cv_speed_c: cover property (indicator_style_select == 2'h1 && portSpeedHigh != 4'h0);
    cv_strap_c: cover property (useDefaults && compound_q);
endmodule
`default_nettype wire

// ### bench/hpcb_cfg_host.sv
// Configuring host model that writes and reads the configuration bytes.
`timescale 1ns/10ps
`default_nettype none
module hpcb_cfg_host #(
    parameter logic [3:0] IND_PINS_OK = 4'hf
) (
    input  wire logic                mclk,
    input  wire logic [7:0]          rdata_q,
    input  wire logic                rvalid_q,
    output var  hpcb_pkg::hpcb_req_s req
);
    // ****************************************
    // Access tasks and legal byte builders
    // ****************************************
    initial req = '0;

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk) req <= '{1'b1, 1'b0, a, d};
        @(posedge mclk) req <= '0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        d = 8'hxx;
        @(posedge mclk) req <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge mclk) req <= '0;
        for (int i = 0; i < 4; i++) begin
            @(negedge mclk);
            if (rvalid_q === 1'b1) begin
                d = rdata_q;
                break;
            end
        end
    endtask

    function automatic logic [7:0] disMask(input int n);
        disMask = 8'h00;
        for (int p = 4; p > 4 - n; p--) begin
            disMask[p] = 1'b1;
        end
    endfunction

    function automatic logic [7:0] ownerByte(input logic [1:0] st, input logic src,
                                             input logic [1:0] ind);
        logic [1:0] useInd;
        useInd = IND_PINS_OK[ind] ? ind : 2'h0;
        ownerByte = {st, src, 2'b00, useInd, 1'b0};
    endfunction
endmodule
`default_nettype wire

// ### bench/hpcb_tb_top.sv
// Self-checking testbench for the hub port configuration bytes.
`timescale 1ns/10ps
`default_nettype none
module hpcb_tb_top;
    // ****************************************
    // Signals, design and host model
    // ****************************************
    logic                  mclk, sys_rst, useDefaults, dynamicPowerEn, local_power_sense;
    hpcb_pkg::hpcb_req_s   req;
    hpcb_pkg::hpcb_strap_s straps;
    logic [2:0]            progSelect;
    logic [3:0]            portSelect, portUnassign, regOwner, portSpeedHigh, portActivity;
    logic [7:0]            rdata_q;
    logic                  rvalid_q, compound_q, stringEn_q, selfPowered_q;
    logic [3:0]            portOwner_q, portAssigned_q, portDisabled_q, portFixed_q;
    logic [3:0]            indA, indB;
    logic [3:0]            aSeen [4];
    logic [3:0]            bSeen [4];
    int                    fail_count, num_checks;

    hpcb_top hpcb_top_inst (.mclk(mclk), .sys_rst(sys_rst), .req(req),
        .useDefaults(useDefaults), .straps(straps), .dynamicPowerEn(dynamicPowerEn),
        .local_power_sense(local_power_sense), .progSelect(progSelect),
        .portSelect(portSelect), .portUnassign(portUnassign), .regOwner(regOwner),
        .portSpeedHigh(portSpeedHigh), .portActivity(portActivity), .rdata_q(rdata_q),
        .rvalid_q(rvalid_q), .portOwner_q(portOwner_q), .portAssigned_q(portAssigned_q),
        .portDisabled_q(portDisabled_q), .portFixed_q(portFixed_q),
        .compound_q(compound_q), .stringEn_q(stringEn_q), .selfPowered_q(selfPowered_q),
        .indicator_a_outputs_n_q(indA), .indicator_b_outputs_n_q(indB));

    hpcb_cfg_host hpcb_cfg_host_inst (.mclk(mclk), .rdata_q(rdata_q), .rvalid_q(rvalid_q),
        .req(req));

    // ****************************************
    // Helper tasks
    // ****************************************
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        hpcb_cfg_host_inst.rd(a, d);
        chk(d, exp);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        hpcb_cfg_host_inst.wr(a, d);
    endtask

    task automatic settle;
        repeat (3) @(posedge mclk);
        @(negedge mclk);
    endtask

    task automatic report_and_stop;
        $display("Checks %0d, mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        {sys_rst, useDefaults, dynamicPowerEn, local_power_sense} = 4'h9;
        {straps, progSelect, portSelect, portUnassign} = '0;
        {regOwner, portSpeedHigh, portActivity} = '0;
        fail_count = 0;
        num_checks = 0;
        repeat (8) @(posedge mclk);
        sys_rst <= 1'b0;
        for (int a = 8; a < 12; a++) begin
            rchk(8'(a), 8'h00);
        end
        wr(hpcb_pkg::OFS_OWNER_CFG, 8'hff);
        rchk(hpcb_pkg::OFS_OWNER_CFG, 8'he7);
        chk({7'h00, stringEn_q}, 8'h01);
        wr(hpcb_pkg::OFS_FIXED_MASK, 8'hff);
        rchk(hpcb_pkg::OFS_FIXED_MASK, 8'h1e);
        wr(hpcb_pkg::OFS_FIXED_MASK, 8'h03);
        wr(8'h0c, 8'hff);
        rchk(8'h0c, 8'h00);
        settle();
        chk({4'h0, portFixed_q}, 8'h01);
        @(posedge mclk) dynamicPowerEn <= 1'b1;
        wr(hpcb_pkg::OFS_SP_DIS_MASK, hpcb_cfg_host_inst.disMask(2));
        wr(hpcb_pkg::OFS_BP_DIS_MASK, hpcb_cfg_host_inst.disMask(3));
        settle();
        chk({4'h0, portDisabled_q}, 8'h0c);
        @(posedge mclk) local_power_sense <= 1'b0;
        settle();
        chk({4'h0, portDisabled_q}, 8'h0e);
        chk({7'h00, selfPowered_q}, 8'h00);
        @(posedge mclk) local_power_sense <= 1'b1;
        useDefaults <= 1'b1;
        straps <= '{fixedStraps: 2'h2, disableStraps: 2'h3};
        settle();
        chk({4'h0, portFixed_q}, 8'h02);
        chk({7'h00, compound_q}, 8'h01);
        chk({4'h0, portDisabled_q}, 8'h0e);
        @(posedge mclk) useDefaults <= 1'b0;
        wr(hpcb_pkg::OFS_SP_DIS_MASK, 8'h00);
        progSelect <= 3'h5;
        wr(hpcb_pkg::OFS_OWNER_CFG, hpcb_cfg_host_inst.ownerByte(2'h0, 1'b0, 2'h0));
        settle();
        chk({4'h0, portOwner_q}, 8'h0a);
        @(posedge mclk) portSelect <= 4'h6;
        wr(hpcb_pkg::OFS_OWNER_CFG, hpcb_cfg_host_inst.ownerByte(2'h1, 1'b0, 2'h0));
        settle();
        chk({portAssigned_q, portOwner_q}, 8'hf6);
        @(posedge mclk) portSelect <= 4'h0;
        portUnassign <= 4'hf;
        wr(hpcb_pkg::OFS_OWNER_CFG, hpcb_cfg_host_inst.ownerByte(2'h2, 1'b0, 2'h0));
        portSelect <= 4'hf;
        settle();
        chk({portAssigned_q, portOwner_q}, 8'hff);
        wr(hpcb_pkg::OFS_OWNER_CFG, hpcb_cfg_host_inst.ownerByte(2'h3, 1'b0, 2'h0));
        settle();
        chk({4'h0, portAssigned_q}, 8'h00);
        @(posedge mclk) portUnassign <= 4'h0;
        regOwner <= 4'h5;
        portActivity <= 4'h3;
        portSpeedHigh <= 4'hc;
        for (int s = 0; s < 4; s++) begin
            wr(hpcb_pkg::OFS_OWNER_CFG, hpcb_cfg_host_inst.ownerByte(2'h3, 1'b1, 2'(s)));
            settle();
            aSeen[s] = indA;
            bSeen[s] = indB;
        end
        chk({portAssigned_q, portOwner_q}, 8'hf5);
        chk({aSeen[0], bSeen[0]}, 8'hde);
        chk({aSeen[1], bSeen[1]}, 8'h7b);
        chk({aSeen[2], bSeen[2]}, 8'h5a);
        chk({aSeen[3], bSeen[3]}, 8'hde);
        @(posedge mclk) sys_rst <= 1'b1;
        repeat (2) @(posedge mclk);
        sys_rst <= 1'b0;
        rchk(hpcb_pkg::OFS_OWNER_CFG, 8'h00);
        report_and_stop();
    end
endmodule
`default_nettype wire
